// ---- sfb_map.vh ----
// Constants of the serial flash bus front end
// Notes on behaviour
// R01: Pause pin acts only while quad_enable_bit is 0; otherwise it is lane 3.
// R02: quad_enable_bit comes out of power-up set, so quad mode is default.
// R03: Pause stops only serial traffic; running write, program or erase go on.
// R04: 24-bit address splits into 4096 4 kB sectors, 32 kB halves, 64 kB blocks.
// R05: Interface works with SPI mode 0 or mode 3; host uses one of them.
// R06: Bits are sampled on rising clock edge, changed after falling edge.
// R07: Opcodes 3Bh, BBh, 92h move two bits per clock on lanes 0 and 1.
// R08: Opcodes 6Bh, EBh, E7h, 94h, 32h move four bits per clock on four lanes.
// R09: Host issues quad commands only while quad_enable_bit is set.
// R10: After power-up device stays unselected until a chip select falling edge.
// R11: Commands are ignored until power-on threshold passes; then state resets.
// R12: Below the power-on threshold during power-down, all commands are ignored.
// R13: Select low means active; select high without write cycle means standby.
// R14: While paused, outputs float, inputs and clock ignored, bit position kept.
// R15: Host has select low before a pause and normally keeps it low throughout.
// R16: Select going high during a pause resets the interface and drops command.
// R17: Pause begins when pause pin goes low while serial clock is low.
// R18: Pause ends when pause pin goes high while serial clock is low.
// R19: While select is high, inputs are ignored and all outputs float.
// R20: A pause pin change during clock high takes effect at next clock low.
`ifndef SFB_MAP_VH
`define SFB_MAP_VH
// Lane modes
`define SFB_MODE_SINGLE 2'h0
`define SFB_MODE_DUAL 2'h1
`define SFB_MODE_QUAD 2'h2
// Dual lane opcodes
`define SFB_OP_DUAL_OUT 8'h3b
`define SFB_OP_DUAL_IO 8'hbb
`define SFB_OP_DUAL_ID 8'h92
// Quad lane opcodes
`define SFB_OP_QUAD_OUT 8'h6b
`define SFB_OP_QUAD_IO 8'heb
`define SFB_OP_QUAD_WORD 8'he7
`define SFB_OP_QUAD_ID 8'h94
`define SFB_OP_QUAD_PROG 8'h32
// Reset values
`define SFB_QE_RST 1'b1
`define SFB_SYNC_INIT 7'h20
// Address field positions
`define SFB_SECTOR_LSB 12
`define SFB_HALF_LSB 15
`define SFB_BLOCK_LSB 16
`define SFB_ADDR_MSB 23
// Frame byte counts
`define SFB_ADDR_LAST 3'h3
`define SFB_BYTE_SAT 3'h4
// Receive buffer shape
`define SFB_RX_WIDTH 9
`define SFB_RX_DEPTH 8
`define SFB_RX_AW 3
`endif

// ---- sfb_sync.v ----
// Two-stage synchroniser for pin inputs
module sfb_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clk, // Block clock
	input wire rst_n, // Asynchronous reset, active low
	input wire [W-1:0] d, // Asynchronous inputs
	output reg [W-1:0] q // Synchronised outputs
);
reg [W-1:0] meta_r;
// First stage feeds only the second stage
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		meta_r <= INIT;
		q <= INIT;
	end else begin
		meta_r <= d;
		q <= meta_r;
	end
end
endmodule

// ---- sfb_fifo.v ----
// Flip-flop FIFO with registered output stage
module sfb_fifo #(
	parameter W = 9,
	parameter D = 8,
	parameter AW = 3
) (
	input wire clk, // Block clock
	input wire rst_n, // Asynchronous reset, active low
	input wire in_valid, // Write request
	output wire in_ready, // Space available
	input wire [W-1:0] in_data, // Write data
	output reg out_valid, // Output word held
	input wire out_ready, // Consumer takes word
	output reg [W-1:0] out_data // Output word
);
localparam [AW:0] FULL = D[AW:0];
reg [W-1:0] mem [0:D-1];
reg [AW-1:0] wr_r;
reg [AW-1:0] rd_r;
reg [AW:0] cnt_r;
wire push;
wire pop;
wire load;
assign in_ready = (cnt_r != FULL);
assign push = in_valid && in_ready;
assign load = (cnt_r != {(AW+1){1'b0}}) && (!out_valid || out_ready);
assign pop = load;
// Storage write
always @(posedge clk) begin
	if (push) begin
		mem[wr_r] <= in_data;
	end
end
// Pointers, count and output stage
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		wr_r <= {AW{1'b0}};
		rd_r <= {AW{1'b0}};
		cnt_r <= {(AW+1){1'b0}};
		out_valid <= 1'b0;
		out_data <= {W{1'b0}};
	end else begin
		if (push) begin
			wr_r <= (wr_r == D - 1) ? {AW{1'b0}} : wr_r + 1'b1;
		end
		if (pop) begin
			rd_r <= (rd_r == D - 1) ? {AW{1'b0}} : rd_r + 1'b1;
			out_data <= mem[rd_r];
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
		if (push && !pop) begin
			cnt_r <= cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
end
endmodule

// ---- sfb_front.v ----
// Serial flash bus front end: select, lanes, pause and address map
`include "sfb_map.vh"
module sfb_front (
	input wire clk, // Block clock, 40 MHz
	input wire rst_n, // Asynchronous reset, active low
	input wire cs_n_i, // Chip select pin, active low
	input wire sck_i, // Serial clock pin
	input wire [3:0] io_in, // Lane pin levels, lane 3 doubles as pause
	output reg [3:0] io_out, // Lane drive values
	output reg [3:0] io_oe, // Lane drive enables, high drives
	input wire por_ok_i, // Supply above power-on threshold
	input wire write_busy, // Internal write cycle running
	input wire qe_wr, // Load quad_enable_bit, one-cycle pulse
	input wire qe_wr_val, // New quad_enable_bit value
	input wire tx_en, // Device drives read data on lanes
	input wire [7:0] tx_data, // Next byte to shift out
	output reg tx_next, // Pulse: tx_data taken
	input wire rx_ready, // Consumer takes received byte
	output wire rx_valid, // Received byte available
	output wire [8:0] rx_data, // Bit 8 marks opcode byte
	input wire ovf_clr, // Clear overflow flag
	output reg overflow_r, // Byte lost, buffer full
	output reg quad_enable_r, // quad_enable_bit
	output reg wp_n_r, // Write-guard pin level, low protects
	output reg [1:0] mode_r, // Current lane mode
	output reg [23:0] addr_r, // Captured byte address
	output reg addr_valid_r, // Address complete this frame
	output reg [11:0] sector_r, // Sector number
	output reg [8:0] half_r, // Half block number
	output reg [7:0] block_r, // Block number
	output reg paused_r, // Pause condition in force
	output reg active_r, // Active power mode
	output reg standby_r // Standby power mode
);
wire cs_s;
wire sck_s;
wire por_s;
wire [3:0] io_s;
reg sck_d_r;
reg armed_r;
reg sel_r;
reg [2:0] bit_cnt_r;
reg [7:0] rx_sh_r;
reg [2:0] byte_cnt_r;
reg [7:0] tx_sh_r;
reg [2:0] tx_cnt_r;
wire fifo_rdy;
wire rise;
wire fall;
wire live;
wire [2:0] lanes;
wire [3:0] cnt_sum;
wire byte_done;
wire [7:0] rx_nxt;
wire [7:0] tx_word;
wire [23:0] addr_nxt;
reg pause_nxt;

// Lanes per clock for a mode
function [2:0] lanes_of;
	input [1:0] m;
	begin
		case (m)
		`SFB_MODE_DUAL: lanes_of = 3'h2;
		`SFB_MODE_QUAD: lanes_of = 3'h4;
		default: lanes_of = 3'h1;
		endcase
	end
endfunction

// Lane mode chosen by an opcode
function [1:0] mode_of;
	input [7:0] op;
	input qe;
	begin
		case (op)
		`SFB_OP_DUAL_OUT, `SFB_OP_DUAL_IO, `SFB_OP_DUAL_ID:
			mode_of = `SFB_MODE_DUAL; // see R07
		`SFB_OP_QUAD_OUT, `SFB_OP_QUAD_IO, `SFB_OP_QUAD_WORD,
		`SFB_OP_QUAD_ID, `SFB_OP_QUAD_PROG:
			mode_of = qe ? `SFB_MODE_QUAD : `SFB_MODE_SINGLE; // see R08
		default: mode_of = `SFB_MODE_SINGLE;
		endcase
	end
endfunction

// Byte shifted left by the lane count
function [7:0] shl;
	input [7:0] v;
	input [1:0] m;
	begin
		case (m)
		`SFB_MODE_DUAL: shl = {v[5:0], 2'h0};
		`SFB_MODE_QUAD: shl = {v[3:0], 4'h0};
		default: shl = {v[6:0], 1'b0};
		endcase
	end
endfunction

// Received lanes merged below the held bits, highest lane first
function [7:0] shin;
	input [7:0] v;
	input [3:0] p;
	input [1:0] m;
	begin
		case (m)
		`SFB_MODE_QUAD: shin = {v[3:0], p};
		`SFB_MODE_DUAL: shin = {v[5:0], p[1:0]};
		default: shin = {v[6:0], p[0]};
		endcase
	end
endfunction

// Lane drive values; single output rides on lane 1
function [3:0] drv_val;
	input [7:0] v;
	input [1:0] m;
	begin
		case (m)
		`SFB_MODE_QUAD: drv_val = v[7:4]; // see R08
		`SFB_MODE_DUAL: drv_val = {2'h0, v[7:6]}; // see R07
		default: drv_val = {2'h0, v[7], 1'b0};
		endcase
	end
endfunction

// Lanes that a mode drives, all others float
function [3:0] drv_en;
	input [1:0] m;
	begin
		case (m)
		`SFB_MODE_QUAD: drv_en = 4'hf;
		`SFB_MODE_DUAL: drv_en = 4'h3;
		default: drv_en = 4'h2;
		endcase
	end
endfunction

// Pins pass two flip-flops before any logic reads them
sfb_sync #(.W(7), .INIT(`SFB_SYNC_INIT)) u_sync (
	.clk(clk),
	.rst_n(rst_n),
	.d({por_ok_i, cs_n_i, sck_i, io_in}),
	.q({por_s, cs_s, sck_s, io_s})
);

// Receive buffer between the link and the consumer
sfb_fifo #(.W(`SFB_RX_WIDTH), .D(`SFB_RX_DEPTH), .AW(`SFB_RX_AW)) u_rx (
	.clk(clk),
	.rst_n(rst_n),
	.in_valid(byte_done),
	.in_ready(fifo_rdy),
	.in_data({(byte_cnt_r == 3'h0), rx_nxt}),
	.out_valid(rx_valid),
	.out_ready(rx_ready),
	.out_data(rx_data)
);

// Serial clock edges; mode 0 and mode 3 both idle cleanly here
assign rise = sck_s && !sck_d_r; // see R05
assign fall = !sck_s && sck_d_r;
// Clock and data count only while selected and not paused
assign live = sel_r && !paused_r; // see R14
assign lanes = lanes_of(mode_r);
assign cnt_sum = {1'b0, bit_cnt_r} + {1'b0, lanes};
assign byte_done = rise && live && cnt_sum[3]; // see R06
assign tx_word = (tx_cnt_r == 3'h0) ? tx_data : tx_sh_r;
assign addr_nxt = {addr_r[15:0], rx_nxt};

// Incoming bits land in lane order, highest lane first
assign rx_nxt = shin(rx_sh_r, io_s, mode_r);

// Pause follows the pin only while the clock is low
always @* begin
	pause_nxt = paused_r; // see R20
	// Deselect or quad mode cancels any pause at once
	if (quad_enable_r || cs_s || !sel_r) begin
		pause_nxt = 1'b0; // see R01
	end else if (!sck_s) begin
		pause_nxt = !io_s[3]; // see R17
	end
end

// Selection, power gating and pause state
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		sck_d_r <= 1'b0;
		armed_r <= 1'b0;
		sel_r <= 1'b0;
		paused_r <= 1'b0;
		active_r <= 1'b0;
		standby_r <= 1'b0;
	end else begin
		sck_d_r <= sck_s;
		// Select arms only after a high level is seen above threshold
		armed_r <= por_s && cs_s; // see R10
		if (!por_s || cs_s) begin
			sel_r <= 1'b0; // see R12
		end else if (armed_r) begin
			sel_r <= 1'b1; // see R11
		end
		// Clock-high pin changes wait for clock low
		paused_r <= pause_nxt; // see R18
		active_r <= sel_r; // see R13
		// Write cycles keep running through a pause
		standby_r <= !sel_r && !write_busy; // see R03
	end
end

// Receive shifting, frame byte count and lane mode
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		bit_cnt_r <= 3'h0;
		rx_sh_r <= 8'h00;
		byte_cnt_r <= 3'h0;
		mode_r <= `SFB_MODE_SINGLE;
	end else if (!sel_r) begin
		// Deselect, also during a pause, drops the command
		bit_cnt_r <= 3'h0; // see R16
		byte_cnt_r <= 3'h0; // see R19
		mode_r <= `SFB_MODE_SINGLE;
	end else if (rise && live) begin
		rx_sh_r <= rx_nxt;
		bit_cnt_r <= cnt_sum[2:0];
		if (byte_done) begin
			if (byte_cnt_r == 3'h0) begin
				mode_r <= mode_of(rx_nxt, quad_enable_r);
			end
			if (byte_cnt_r != `SFB_BYTE_SAT) begin
				byte_cnt_r <= byte_cnt_r + 3'h1;
			end
		end
	end
end

// Address capture and sector, half block and block decode
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		addr_r <= 24'h000000;
		addr_valid_r <= 1'b0;
		sector_r <= 12'h000;
		half_r <= 9'h000;
		block_r <= 8'h00;
	end else if (!sel_r) begin
		addr_valid_r <= 1'b0;
	end else if (byte_done && byte_cnt_r != 3'h0 &&
		byte_cnt_r <= `SFB_ADDR_LAST) begin
		addr_r <= addr_nxt;
		if (byte_cnt_r == `SFB_ADDR_LAST) begin
			addr_valid_r <= 1'b1;
			sector_r <= addr_nxt[`SFB_ADDR_MSB:`SFB_SECTOR_LSB]; // see R04
			half_r <= addr_nxt[`SFB_ADDR_MSB:`SFB_HALF_LSB];
			block_r <= addr_nxt[`SFB_ADDR_MSB:`SFB_BLOCK_LSB];
		end
	end
end

// Transmit: lanes change after the falling clock edge
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		tx_sh_r <= 8'h00;
		tx_cnt_r <= 3'h0;
		tx_next <= 1'b0;
		io_out <= 4'h0;
		io_oe <= 4'h0;
	end else begin
		tx_next <= 1'b0;
		if (!sel_r) begin
			tx_cnt_r <= 3'h0;
			io_oe <= 4'h0; // see R19
		end else if (paused_r || !tx_en) begin
			// Floating lanes, bit position held for resume
			io_oe <= 4'h0; // see R14
		end else if (fall) begin
			tx_sh_r <= shl(tx_word, mode_r);
			tx_cnt_r <= tx_cnt_r + lanes;
			tx_next <= (tx_cnt_r == 3'h0);
			// Lanes of the mode carry the top bits of the byte
			io_out <= drv_val(tx_word, mode_r); // see R06
			io_oe <= drv_en(mode_r);
		end
	end
end

// quad_enable_bit, write-guard pin and overflow flag
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		quad_enable_r <= `SFB_QE_RST; // see R02
		wp_n_r <= 1'b1;
		overflow_r <= 1'b0;
	end else begin
		if (qe_wr) begin
			quad_enable_r <= qe_wr_val;
		end
		// Write-guard function exists only outside quad mode
		wp_n_r <= quad_enable_r ? 1'b1 : io_s[2]; // see R01
		// A lost byte sets the flag even in a clear cycle
		if (byte_done && !fifo_rdy) begin
			overflow_r <= 1'b1;
		end else if (ovf_clr) begin
			overflow_r <= 1'b0;
		end
	end
end
endmodule

// ---- sfb_front_assertions.sv ----
// Port checker of the serial flash bus front end
module sfb_front_checker (
	input wire clk, // Clock
	input wire rst_n, // Reset
	input wire cs_n_i, // Select
	input wire por_ok_i, // Supply good
	input wire write_busy, // Write running
	input wire [3:0] io_oe, // Lane enables
	input wire [1:0] mode_r, // Lane mode
	input wire [23:0] addr_r, // Address
	input wire addr_valid_r, // Address done
	input wire [11:0] sector_r, // Sector
	input wire [8:0] half_r, // Half block
	input wire [7:0] block_r, // Block
	input wire quad_enable_r, // Quad enable
	input wire paused_r, // Paused
	input wire active_r, // Active
	input wire standby_r // Standby
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Reset, pause, float, power mode and address map relations
	a_qe_reset: assert property ($rose(rst_n) |-> quad_enable_r)
		else $error("quad enable clear after reset");
	a_pause_qe: assert property (quad_enable_r |-> !paused_r)
		else $error("pause with quad enable set");
	a_pause_float: assert property (paused_r && $past(paused_r)
		|-> io_oe == 4'h0) else $error("lanes driven in pause");
	a_desel_float: assert property (cs_n_i [*6] |-> io_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_desel_pause: assert property (cs_n_i [*6] |-> !paused_r)
		else $error("pause kept after deselect");
	a_standby_on: assert property ((cs_n_i && !write_busy) [*6]
		|-> standby_r) else $error("standby missing");
	a_busy_awake: assert property (write_busy |=> !standby_r)
		else $error("standby during write cycle");
	a_active_on: assert property ((!cs_n_i && por_ok_i) [*8]
		|-> active_r && !standby_r) else $error("active missing");
	a_addr_map: assert property (addr_valid_r && $stable(addr_r)
		|-> {sector_r, half_r, block_r} ==
		{addr_r[23:12], addr_r[23:15], addr_r[23:16]})
		else $error("address map wrong");
	a_single_lane: assert property (mode_r == 2'h0
		|-> io_oe[0] == 1'b0 && io_oe[3:2] == 2'h0)
		else $error("extra lane driven in single mode");
	c_pause: cover property (paused_r);
	c_dual: cover property (mode_r == 2'h1);
	c_quad: cover property (mode_r == 2'h2);
endmodule

// ---- sfb_host.sv ----
// Host controller model: select, serial clock and lanes
module sfb_host (
	input wire clk, // Bench clock
	output logic cs_n, // Select, active low
	output logic sck, // Serial clock
	output logic [3:0] d, // Lane values
	output logic [3:0] oe // Lane enables
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hold = 0; // Stalls between bits
	logic cpol = 0; // Clock idle level, 1 for mode 3
	int hp = 4; // Half period in block clocks
	// Idle deselected with clock low, mode 0
	initial begin
		cs_n = 1;
		sck = 0;
		d = 0;
		oe = 0;
	end
	task hw;
		repeat (hp) @(negedge clk);
	endtask
	// Falling select after a high spell, held low for the frame
	task sel;
		hw;
		cs_n = 0;
		repeat (8) @(negedge clk);
	endtask
	task desel;
		hw;
		cs_n = 1;
		hw;
		oe = 0;
	endtask
	// One byte msb first; quad only while quad enable is set
	task xfer(input [7:0] b, input [1:0] m);
		int n;
		logic [7:0] s;
		n = m == 2'h2 ? 4 : m == 2'h1 ? 2 : 1;
		s = b;
		oe[2:0] = m == 2'h2 ? 3'h7 : m == 2'h1 ? 3'h3 : 3'h1;
		if (m == 2'h2) oe[3] = 1'b1;
		// Mode 3 drops the idle-high clock before the first bit
		sck = 1'b0;
		for (int k = 0; k < 8 / n; k++) begin
			for (int w = 0; w < 400 && hold; w++) @(negedge clk);
			case (n)
				4: d = s[7:4];
				2: d[1:0] = s[7:6];
				default: d[0] = s[7];
			endcase
			s = s << n;
			hw;
			sck = 1;
			hw;
			sck = cpol && k == 8 / n - 1;
		end
		hw;
	endtask
	// Pause pin moved only while the clock is low
	task pz(input on);
		d[3] = !on;
		oe[3] = 1'b1;
	endtask
	task wig;
		repeat (2) begin
			sck = 1;
			hw;
			sck = 0;
			hw;
		end
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the serial flash bus front end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, por = 0, wb = 0, qw = 0, qv = 0, tg = 0;
	logic txe = 0, rr = 1, oc = 0, cs_n, sck, tx_next, rx_valid, ovf, qe;
	logic wp, av, pz, act, sb;
	logic [7:0] txd = 8'h00, blk;
	logic [3:0] io, io_out, io_oe, hd, hoe;
	logic [8:0] rx_data, half, exq[$];
	logic [1:0] mode;
	logic [23:0] addr, a;
	logic [11:0] sec;
	logic [7:0] ops[9] = '{8'h03, 8'h3b, 8'hbb, 8'h92, 8'h6b, 8'heb,
		8'he7, 8'h94, 8'h32};
	logic [1:0] mds[9] = '{0, 1, 1, 1, 2, 2, 2, 2, 2};
	int num_errors = 0, comparisons = 0, nx = 0;
	sfb_front i_sfb_front(.clk, .rst_n, .cs_n_i(cs_n), .sck_i(sck),
		.io_in(io), .io_out, .io_oe, .por_ok_i(por), .write_busy(wb),
		.qe_wr(qw), .qe_wr_val(qv), .tx_en(txe), .tx_data(txd), .tx_next,
		.rx_ready(rr), .rx_valid, .rx_data, .ovf_clr(oc), .overflow_r(ovf),
		.quad_enable_r(qe), .wp_n_r(wp), .mode_r(mode), .addr_r(addr),
		.addr_valid_r(av), .sector_r(sec), .half_r(half), .block_r(blk),
		.paused_r(pz), .active_r(act), .standby_r(sb));
	sfb_host i_sfb_host(.clk, .cs_n, .sck, .d(hd), .oe(hoe));
	// Clock at 40 MHz
	initial forever #12.5 clk = ~clk;
	// Released lanes: pull-ups on 2 and 3, a changing level on 0 and 1
	always @(negedge clk) tg <= ~tg;
	always_comb for (int i = 0; i < 4; i++)
		io[i] = io_oe[i] ? io_out[i] : hoe[i] ? hd[i] : i > 1 ? 1'b1 : tg;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task snd(input [7:0] b, input [1:0] m, input f);
		exq.push_back({f, b});
		i_sfb_host.xfer(b, m);
	endtask
	task wait_q;
		for (int n = 0; n < 400 && exq.size() > 0; n++) @(negedge clk);
		if (exq.size() > 0) begin
			num_errors++;
			report_and_stop;
		end
	endtask
	task frm(input [7:0] op, input [1:0] m, input [23:0] ad);
		i_sfb_host.sel;
		snd(op, 2'h0, 1'b1);
		for (int k = 2; k >= 0; k--) snd(ad[8 * k +: 8], m, 1'b0);
		wait_q;
	endtask
	// Matches each word leaving the buffer with the oldest note
	// Looks just after the falling edge, when outputs and rr have settled
	always @(negedge clk) begin
		#1;
		if (tx_next === 1'b1) nx++;
		if (rx_valid === 1'b1 && rr) begin
			if (exq.size() > 0) chk(rx_data, exq.pop_front());
			else chk({1'b1, rx_data}, 0);
		end
	end
	// Main sequence
	initial begin
		void'($urandom(40156));
		repeat (3) @(negedge clk);
		rst_n = 1;
		por = 1;
		repeat (8) @(negedge clk);
		chk(qe, 1);
		chk(wp, 1);
		chk(sb, 1);
		$display("reset test done");
		foreach (ops[i]) begin
			a = i < 8 ? 24'($urandom) : 24'hffffff;
			// Odd frames run in mode 3, clock idling high
			i_sfb_host.cpol = i[0];
			i_sfb_host.sck = i[0];
			frm(ops[i], mds[i], a);
			chk(mode, mds[i]);
			chk({sec, half, blk}, {a[23:12], a[23:15], a[23:16]});
			chk(av, 1);
			chk(act, 1);
			i_sfb_host.desel;
		end
		$display("lane test done");
		qw = 1;
		@(negedge clk);
		qw = 0;
		@(negedge clk);
		chk(qe, 0);
		// Write-guard pin is mirrored once quad mode is off
		i_sfb_host.d[2] = 1'b0;
		i_sfb_host.oe[2] = 1'b1;
		repeat (4) @(negedge clk);
		chk(wp, 0);
		frm(8'h6b, 2'h0, 24'h00abcd);
		chk(mode, 0);
		fork
			snd(8'ha5, 2'h0, 1'b0);
			begin
				repeat (20) @(negedge clk);
				i_sfb_host.hold = 1;
				repeat (10) @(negedge clk);
				i_sfb_host.pz(1);
				repeat (8) @(negedge clk);
				chk(pz, 1);
				i_sfb_host.wig;
				i_sfb_host.pz(0);
				repeat (8) @(negedge clk);
				chk(pz, 0);
				i_sfb_host.hold = 0;
			end
		join
		wait_q;
		i_sfb_host.pz(1);
		repeat (8) @(negedge clk);
		i_sfb_host.cs_n = 1;
		repeat (8) @(negedge clk);
		chk(pz, 0);
		i_sfb_host.pz(0);
		i_sfb_host.desel;
		wb = 1;
		repeat (4) @(negedge clk);
		chk(sb, 0);
		wb = 0;
		$display("pause test done");
		txe = 1;
		txd = 8'($urandom);
		i_sfb_host.sel;
		fork
			snd(8'h0b, 2'h0, 1'b1);
			begin
				repeat (4) @(negedge clk);
				i_sfb_host.hold = 1;
				repeat (16) @(negedge clk);
				chk(io_oe, 4'h2);
				chk(io_out[1], txd[7]);
				i_sfb_host.hold = 0;
			end
		join
		wait_q;
		chk(nx, 1);
		txe = 0;
		i_sfb_host.desel;
		$display("read test done");
		rr = 0;
		i_sfb_host.sel;
		snd(8'h9f, 2'h0, 1'b1);
		repeat (7) snd(8'($urandom), 2'h0, 1'b0);
		// Ninth byte fills the output stage and all eight slots
		snd(8'h5a, 2'h0, 1'b0);
		repeat (3) i_sfb_host.xfer(8'h5a, 2'h0);
		chk(ovf, 1);
		rr = 1;
		wait_q;
		repeat (30) @(negedge clk);
		oc = 1;
		@(negedge clk);
		oc = 0;
		@(negedge clk);
		chk(ovf, 0);
		i_sfb_host.desel;
		$display("buffer test done");
		report_and_stop;
	end
endmodule
bind sfb_front sfb_front_checker i_chk(.clk, .rst_n, .cs_n_i, .por_ok_i,
	.write_busy, .io_oe, .mode_r, .addr_r, .addr_valid_r, .sector_r,
	.half_r, .block_r, .quad_enable_r, .paused_r, .active_r, .standby_r);
